// ### design/abm_pkg.sv
// Constants and types for the address bank mode control block
package abm_pkg;
    // Instruction codes
    localparam logic [7:0] CMD_BANK_RD   = 8'h16;
    localparam logic [7:0] CMD_BANK_WR   = 8'h17;
    localparam logic [7:0] CMD_WREN      = 8'h06;
    localparam logic [7:0] CMD_SOFT_RST  = 8'hf0;
    localparam logic [7:0] CMD_SR1_WR    = 8'h01;
    localparam logic [7:0] CMD_SR1_RD    = 8'h05;
    localparam logic [7:0] CMD_SFDP_RD   = 8'h5a;
    localparam logic [7:0] CMD_READ3     = 8'h03;
    localparam logic [7:0] CMD_READ4     = 8'h13;

    // Bank register layout
    localparam int         BANK_MODE_BIT = 7;
    localparam int         SEG_LO        = 24;
    localparam int         SEG_HI        = 30;
    localparam logic [7:0] BANK_RESET    = 8'h00;

    // Status register 1
    localparam logic [7:0] SR1_RESET     = 8'h00;
    localparam logic [7:0] SR1_WR_MASK   = 8'hfc;
    localparam int         SR1_WEL_BIT   = 1;

    // Byte counts of the address phases
    localparam logic [2:0] ADDR3_BYTES   = 3'h3;
    localparam logic [2:0] ADDR4_BYTES   = 3'h4;
    localparam logic [2:0] SFDP_PHASE    = 3'h4;

    // Discovery table contents
    localparam logic [7:0]  SFDP_DW16_ADDR = 8'h3c;
    localparam logic [31:0] SFDP_DW16      = 32'ha8fa28f0;
    localparam logic [7:0]  SMAP_HDR_ADDR  = 8'h40;
    localparam logic [7:0]  SMAP_DESC      = 8'hff;
    localparam logic [7:0]  SMAP_CFG_ID    = 8'h00;
    localparam logic [7:0]  SMAP_REGIONS   = 8'h00;
    localparam logic [7:0]  SMAP_RFU       = 8'hff;
    localparam logic [7:0]  SFDP_BLANK     = 8'hff;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_DIN, ST_OUT, ST_IGN
    } abm_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } abm_arr_req_t;
endpackage : abm_pkg

// ### design/abm_top.sv
// SPI command interpreter for address bank mode, status write enable, SFDP
// What this block does, and what its host must do
// RULE1 - Instruction 16h returns the 8-bit bank register
// RULE2 - Instruction 17h with exactly one data byte loads the bank register
// RULE3 - Bank register is volatile, 8 bits, holds address bits 30..24
// RULE4 - Bit 7 low: three-byte addresses, bank bits pick 128 Mbit segment
// RULE5 - Bit 7 high: four-byte addresses, bank segment bits ignored
// RULE6 - Dedicated four-byte instructions work regardless of bank mode
// RULE7 - Hardware reset, software reset and power cycle leave four-byte mode
// RULE8 - Instruction F0h performs a software reset
// RULE9 - Host leaves continuous quad read mode before other reset sequences
// RULE10 - 06h enables status register 1 writes; writes without it refused
// RULE11 - Discovery dword 16 reads F0, 28, FA, A8 lowest byte first
// RULE12 - Sector map header reports region count 00h
// RULE13 - Sector map header reports configuration id 00h, uniform sectors
// RULE14 - Header byte sets descriptor and last bits; top byte reads FFh
// RULE15 - Leaving four-byte mode by a reset clears the whole bank register; a 17h write loads its byte as is
`timescale 1ns/1ps
module abm_top (
    input  wire logic                  sys_clk,    // 200 MHz block clock
    input  wire logic                  rst_b,      // Async reset, low
    input  wire logic                  spi_cs_b,   // Chip select pin, low
    input  wire logic                  spi_sclk,   // Serial clock pin
    input  wire logic                  spi_si,     // Serial data in pin
    output logic                       spi_so,     // Serial data out
    output logic                       spi_so_oe,  // Drive enable for so
    output abm_pkg::abm_arr_req_t      arr_req,    // Array address pulse
    output logic                       addr_4byte, // Four-byte mode level
    output logic [7:0]                 bank_sel    // Bank register value
);

    // Synchronisers; first stages feed only the second stages
    logic       cs_s1, cs_s2, cs_s3;
    logic       ck_s1, ck_s2, ck_s3;
    logic       si_s1, si_s2;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            cs_s1 <= spi_cs_b;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            ck_s1 <= spi_sclk;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            si_s1 <= spi_si;
            si_s2 <= si_s1;
        end
    end

    // Data shares the clock's latency, so sampling stays aligned
    logic       cs_act, sclk_rise, sclk_fall, frame_end;
    assign cs_act    = ~cs_s2;
    assign sclk_rise = ck_s2 & ~ck_s3;
    assign sclk_fall = ~ck_s2 & ck_s3;
    assign frame_end = cs_s2 & ~cs_s3;

    function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
        logic [31:0] hdr;
        hdr = {abm_pkg::SMAP_RFU, abm_pkg::SMAP_REGIONS,
               abm_pkg::SMAP_CFG_ID, abm_pkg::SMAP_DESC}; // RULE12 RULE13
        if (a[7:2] == abm_pkg::SFDP_DW16_ADDR[7:2])
            sfdp_byte = abm_pkg::SFDP_DW16[8*a[1:0] +: 8]; // RULE11
        else if (a[7:2] == abm_pkg::SMAP_HDR_ADDR[7:2])
            sfdp_byte = hdr[8*a[1:0] +: 8]; // RULE14
        else
            sfdp_byte = abm_pkg::SFDP_BLANK;
    endfunction : sfdp_byte

    abm_pkg::abm_state_t   state_reg, state_next;
    logic [2:0]            bitcnt_reg, bitcnt_next;
    logic [7:0]            shift_reg, shift_next;
    logic [7:0]            cmd_reg, cmd_next;
    logic [31:0]           addr_reg, addr_next;
    logic [2:0]            acnt_reg, acnt_next;
    logic [1:0]            dcnt_reg, dcnt_next;
    logic [7:0]            data_reg, data_next;
    logic [7:0]            bank_reg, bank_next;
    logic                  wel_reg, wel_next;
    logic [7:0]            sr1_reg, sr1_next;
    logic [7:0]            out_reg, out_next;
    logic                  so_reg, so_next;
    logic                  oe_reg, oe_next;
    abm_pkg::abm_arr_req_t req_reg, req_next;

    logic       byte_done;
    logic [7:0] rx_byte;
    logic [7:0] sr1_view;
    logic [2:0] abytes, total;
    logic       soft_hit;
    logic [31:0] addr_full;

    assign byte_done = cs_act & sclk_rise & (bitcnt_reg == 3'h7);
    assign rx_byte   = {shift_reg[6:0], si_s2};
    assign soft_hit  = byte_done & (state_reg == abm_pkg::ST_CMD)
                       & (rx_byte == abm_pkg::CMD_SOFT_RST);
    assign sr1_view  = sr1_reg | ({7'h00, wel_reg} << abm_pkg::SR1_WEL_BIT);
    // Dedicated four-byte read ignores the mode bit; discovery reads
    // always take three address bytes, else the dummy would shift in
    assign abytes = (cmd_reg == abm_pkg::CMD_READ4 ||
                     (bank_reg[abm_pkg::BANK_MODE_BIT] &&
                      cmd_reg != abm_pkg::CMD_SFDP_RD))
                    ? abm_pkg::ADDR4_BYTES : abm_pkg::ADDR3_BYTES; // RULE6
    assign total  = (cmd_reg == abm_pkg::CMD_SFDP_RD)
                    ? abm_pkg::SFDP_PHASE : abytes;
    assign addr_full = {addr_reg[23:0], rx_byte};

    always_comb begin
        state_next  = state_reg;
        bitcnt_next = bitcnt_reg;
        shift_next  = shift_reg;
        cmd_next    = cmd_reg;
        addr_next   = addr_reg;
        acnt_next   = acnt_reg;
        dcnt_next   = dcnt_reg;
        data_next   = data_reg;
        bank_next   = bank_reg;
        wel_next    = wel_reg;
        sr1_next    = sr1_reg;
        out_next    = out_reg;
        so_next     = so_reg;
        oe_next     = oe_reg;
        req_next    = req_reg;
        req_next.valid = 1'b0;
        if (frame_end) begin
            // Writes commit only with exactly one data byte in the frame
            if (cmd_reg == abm_pkg::CMD_BANK_WR && dcnt_reg == 2'h1 &&
                state_reg == abm_pkg::ST_DIN)
                bank_next = data_reg; // RULE2 RULE3
            if (cmd_reg == abm_pkg::CMD_SR1_WR && dcnt_reg == 2'h1 &&
                state_reg == abm_pkg::ST_DIN && wel_reg) begin // RULE10
                sr1_next = data_reg & abm_pkg::SR1_WR_MASK;
                wel_next = 1'b0;
            end
            state_next  = abm_pkg::ST_CMD;
            bitcnt_next = 3'h0;
            acnt_next   = 3'h0;
            dcnt_next   = 2'h0;
            oe_next     = 1'b0;
        end else if (cs_act) begin
            if (sclk_fall && state_reg == abm_pkg::ST_OUT) begin
                so_next  = out_reg[7];
                out_next = {out_reg[6:0], 1'b1};
                oe_next  = 1'b1;
            end
            if (sclk_rise) begin
                bitcnt_next = bitcnt_reg + 3'h1;
                shift_next  = rx_byte;
            end
            if (byte_done) begin
                unique case (state_reg)
                    abm_pkg::ST_CMD: begin
                        cmd_next = rx_byte;
                        case (rx_byte)
                            abm_pkg::CMD_BANK_RD: begin
                                out_next   = bank_reg; // RULE1
                                state_next = abm_pkg::ST_OUT;
                            end
                            abm_pkg::CMD_SR1_RD: begin
                                out_next   = sr1_view;
                                state_next = abm_pkg::ST_OUT;
                            end
                            abm_pkg::CMD_BANK_WR,
                            abm_pkg::CMD_SR1_WR:
                                state_next = abm_pkg::ST_DIN;
                            abm_pkg::CMD_WREN: begin
                                wel_next   = 1'b1; // RULE10
                                state_next = abm_pkg::ST_IGN;
                            end
                            abm_pkg::CMD_SOFT_RST: begin
                                // Also drops four-byte mode
                                bank_next  =
                                    abm_pkg::BANK_RESET; // RULE8 RULE7 RULE15
                                wel_next   = 1'b0;
                                state_next = abm_pkg::ST_IGN;
                            end
                            abm_pkg::CMD_SFDP_RD,
                            abm_pkg::CMD_READ3,
                            abm_pkg::CMD_READ4:
                                state_next = abm_pkg::ST_ADDR;
                            default:
                                state_next = abm_pkg::ST_IGN;
                        endcase
                    end
                    abm_pkg::ST_ADDR: begin
                        acnt_next = acnt_reg + 3'h1;
                        // The SFDP dummy byte is not shifted into the address
                        if (acnt_reg < abytes)
                            addr_next = addr_full;
                        if (acnt_reg == total - 3'h1) begin
                            if (cmd_reg == abm_pkg::CMD_SFDP_RD) begin
                                out_next   = sfdp_byte(addr_reg[7:0]);
                                state_next = abm_pkg::ST_OUT;
                            end else begin
                                req_next.valid = 1'b1;
                                if (abytes == abm_pkg::ADDR4_BYTES)
                                    req_next.addr = {1'b0,
                                        addr_full[30:0]}; // RULE5 RULE6
                                else
                                    req_next.addr = {1'b0, bank_reg[6:0],
                                        addr_full[23:0]}; // RULE4
                                state_next = abm_pkg::ST_IGN;
                            end
                        end
                    end
                    abm_pkg::ST_DIN: begin
                        data_next = rx_byte;
                        if (dcnt_reg != 2'h3)
                            dcnt_next = dcnt_reg + 2'h1;
                    end
                    abm_pkg::ST_OUT: begin
                        if (cmd_reg == abm_pkg::CMD_SFDP_RD) begin
                            addr_next = addr_reg + 32'h1;
                            out_next  = sfdp_byte(addr_reg[7:0] + 8'h1);
                        end else if (cmd_reg == abm_pkg::CMD_BANK_RD)
                            out_next = bank_reg; // RULE1
                        else
                            out_next = sr1_view;
                    end
                    abm_pkg::ST_IGN: begin
                    end
                endcase
            end
        end
    end

    // Reset clears the bank, so power-up is three-byte, segment zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= abm_pkg::ST_CMD;
            bitcnt_reg <= 3'h0;
            shift_reg  <= 8'h00;
            cmd_reg    <= 8'h00;
            addr_reg   <= 32'h0;
            acnt_reg   <= 3'h0;
            dcnt_reg   <= 2'h0;
            data_reg   <= 8'h00;
            bank_reg   <= abm_pkg::BANK_RESET; // RULE7 RULE15
            wel_reg    <= 1'b0;
            sr1_reg    <= abm_pkg::SR1_RESET;
            out_reg    <= 8'hff;
            so_reg     <= 1'b0;
            oe_reg     <= 1'b0;
            req_reg    <= '0;
        end else begin
            state_reg  <= state_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg  <= shift_next;
            cmd_reg    <= cmd_next;
            addr_reg   <= addr_next;
            acnt_reg   <= acnt_next;
            dcnt_reg   <= dcnt_next;
            data_reg   <= data_next;
            bank_reg   <= bank_next;
            wel_reg    <= wel_next;
            sr1_reg    <= sr1_next;
            out_reg    <= out_next;
            so_reg     <= so_next;
            oe_reg     <= oe_next;
            req_reg    <= req_next;
        end
    end

    assign spi_so     = so_reg;
    assign spi_so_oe  = oe_reg;
    assign arr_req    = req_reg;
    assign addr_4byte = bank_reg[abm_pkg::BANK_MODE_BIT];
    assign bank_sel   = bank_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_bank_rd;
        byte_done && state_reg == abm_pkg::ST_CMD &&
        rx_byte == abm_pkg::CMD_BANK_RD && !frame_end
        |=> state_reg == abm_pkg::ST_OUT && out_reg == $past(bank_reg);
    endproperty
    a_bank_rd: assert property (p_bank_rd) // RULE1
        else $error("bank read did not load bank value");

    property p_bank_wr;
        frame_end && cmd_reg == abm_pkg::CMD_BANK_WR &&
        state_reg == abm_pkg::ST_DIN && dcnt_reg == 2'h1
        |=> bank_reg == $past(data_reg);
    endproperty
    a_bank_wr: assert property (p_bank_wr) // RULE2
        else $error("bank write byte not loaded");

    property p_bank_stable;
        $changed(bank_reg) |-> $past(soft_hit) ||
            ($past(frame_end) && $past(cmd_reg) == abm_pkg::CMD_BANK_WR);
    endproperty
    a_bank_stable: assert property (p_bank_stable) // RULE3
        else $error("bank register changed without cause");

    property p_seg3;
        req_reg.valid && !bank_reg[abm_pkg::BANK_MODE_BIT] &&
        cmd_reg == abm_pkg::CMD_READ3
        |-> req_reg.addr[abm_pkg::SEG_HI:abm_pkg::SEG_LO] == bank_reg[6:0]
            && acnt_reg == abm_pkg::ADDR3_BYTES;
    endproperty
    a_seg3: assert property (p_seg3) // RULE4
        else $error("three-byte address lost segment bits");

    property p_mode4;
        req_reg.valid && bank_reg[abm_pkg::BANK_MODE_BIT]
        |-> acnt_reg == abm_pkg::ADDR4_BYTES &&
            req_reg.addr[30:0] == addr_reg[30:0];
    endproperty
    a_mode4: assert property (p_mode4) // RULE5
        else $error("four-byte mode address wrong");

    property p_cmd4;
        req_reg.valid && cmd_reg == abm_pkg::CMD_READ4
        |-> acnt_reg == abm_pkg::ADDR4_BYTES &&
            req_reg.addr[30:0] == addr_reg[30:0];
    endproperty
    a_cmd4: assert property (p_cmd4) // RULE6
        else $error("dedicated four-byte read address wrong");

    property p_soft;
        soft_hit && !frame_end
        |=> bank_reg == abm_pkg::BANK_RESET && !addr_4byte && !wel_reg
            ##1 state_reg == abm_pkg::ST_IGN || !cs_act;
    endproperty
    a_soft: assert property (p_soft) // RULE8 RULE7 RULE15
        else $error("software reset left bank state");

    property p_sr_refuse;
        frame_end && cmd_reg == abm_pkg::CMD_SR1_WR && !wel_reg
        |=> $stable(sr1_reg);
    endproperty
    a_sr_refuse: assert property (p_sr_refuse) // RULE10
        else $error("status write accepted without enable");

    property p_sfdp;
        byte_done && !frame_end && state_reg == abm_pkg::ST_OUT &&
        cmd_reg == abm_pkg::CMD_SFDP_RD
        |=> out_reg == sfdp_byte(addr_reg[7:0]) &&
            addr_reg == $past(addr_reg) + 32'h1;
    endproperty
    a_sfdp: assert property (p_sfdp) // RULE11 RULE12 RULE13 RULE14
        else $error("discovery byte mismatch");

    c_bank_wr: cover property (frame_end && cmd_reg == abm_pkg::CMD_BANK_WR
        && dcnt_reg == 2'h1);
    c_mode4:   cover property (req_reg.valid && addr_4byte);
    c_soft:    cover property (soft_hit && addr_4byte);
    c_sfdp:    cover property (state_reg == abm_pkg::ST_OUT &&
        cmd_reg == abm_pkg::CMD_SFDP_RD && addr_reg[7:0] == 8'h43);

endmodule : abm_top

// ### tb/abm_host_model.sv
// Behavioural SPI host that frames commands toward the block
`timescale 1ns/1ps
module abm_host_model (
    input  wire logic clk,    // Block clock, used as time base
    output logic      cs_b,   // Chip select, low
    output logic      sclk,   // Serial clock, mode 0
    output logic      si,     // Serial data to the block
    input  wire logic so,     // Serial data from the block
    input  wire logic so_oe   // Block drive enable
);
    localparam int HALF = 16; // 80 ns half period at 5 ns

    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        si   = 1'b1;
    end

    // Never enters continuous quad read, so no exit sequence is due
    task automatic start();
        @(negedge clk);
        cs_b = 1'b0;
        repeat (HALF) @(negedge clk);
    endtask : start

    // Clock only toggles inside frames
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                        output logic oe);
        oe = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            si = d[i];
            repeat (HALF) @(negedge clk);
            sclk = 1'b1;
            q[i] = so;
            oe   = oe & so_oe;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
    endtask : xfer

    task automatic stop();
        repeat (HALF) @(negedge clk);
        cs_b = 1'b1;
        si   = ~si; // Released line must not look like held data
        repeat (8) @(negedge clk);
    endtask : stop
endmodule : abm_host_model

// ### tb/abm_top_tb_top.sv
// Self-checking bench for the address bank mode control block
`timescale 1ns/1ps
module abm_top_tb_top;
    logic                  sys_clk;
    logic                  rst_b;
    logic                  spi_cs_b;
    logic                  spi_sclk;
    logic                  spi_si;
    logic                  spi_so;
    logic                  spi_so_oe;
    abm_pkg::abm_arr_req_t arr_req;
    logic                  addr_4byte;
    logic [7:0]            bank_sel;
    logic [7:0]            tx [16];
    logic [7:0]            rx [16];
    logic                  rx_oe [16];
    logic [31:0]           req_addr;
    int                    req_cnt;
    int                    fails;
    int                    n_tests;

    abm_top dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
        .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .arr_req(arr_req),
        .addr_4byte(addr_4byte), .bank_sel(bank_sel)
    );

    abm_host_model host (
        .clk(sys_clk), .cs_b(spi_cs_b), .sclk(spi_sclk), .si(spi_si),
        .so(spi_so), .so_oe(spi_so_oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Sampled mid-cycle, clear of the edge that launches the pulse
    always @(negedge sys_clk) begin
        if (arr_req.valid === 1'b1) begin
            req_cnt  <= req_cnt + 1;
            req_addr <= arr_req.addr;
        end
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : check

    task automatic run_frame(input int n);
        host.start();
        for (int i = 0; i < n; i++)
            host.xfer(tx[i], rx[i], rx_oe[i]);
        host.stop();
    endtask : run_frame

    task automatic bank_wr(input logic [7:0] d);
        tx[0] = abm_pkg::CMD_BANK_WR;
        tx[1] = d;
        run_frame(2);
    endtask : bank_wr

    task automatic t_reset_values();
        check(bank_sel, 32'h00, "bank after reset");
        check(addr_4byte, 32'h0, "mode after reset");
        check(spi_so_oe, 32'h0, "oe after reset");
    endtask : t_reset_values

    task automatic t_bank_rw();
        bank_wr(8'h85);
        check(bank_sel, 32'h85, "bank load");
        check(addr_4byte, 32'h1, "four byte mode");
        tx[0] = abm_pkg::CMD_BANK_RD;
        run_frame(3);
        check(rx[1], 32'h85, "bank read");
        check(rx[2], 32'h85, "bank read repeat");
        check(rx_oe[1], 32'h1, "oe while reading");
    endtask : t_bank_rw

    task automatic t_bank_refused();
        tx[0] = abm_pkg::CMD_BANK_WR;
        tx[1] = 8'h11;
        tx[2] = 8'h22;
        run_frame(3);
        check(bank_sel, 32'h85, "two data bytes");
        run_frame(1);
        check(bank_sel, 32'h85, "no data byte");
        tx[0] = 8'h9f;
        run_frame(2);
        check(bank_sel, 32'h85, "unknown opcode");
        check(rx_oe[1], 32'h0, "unknown opcode drove");
    endtask : t_bank_refused

    task automatic addr_case(input logic [7:0] bank, input logic [7:0] op,
                             input logic [31:0] a, input int n,
                             input logic [31:0] exp);
        bank_wr(bank);
        req_cnt = 0;
        tx[0] = op;
        for (int i = 0; i < n; i++)
            tx[1 + i] = a[8 * (n - 1 - i) +: 8];
        run_frame(n + 1);
        check(req_cnt, 32'h1, "request count");
        check(req_addr, exp, "array address");
    endtask : addr_case

    task automatic t_addr();
        addr_case(8'h05, 8'h03, 32'h123456, 3, 32'h05123456);
        addr_case(8'h7f, 8'h03, 32'hffffff, 3, 32'h7fffffff);
        addr_case(8'h85, 8'h03, 32'h9abcdef0, 4, 32'h1abcdef0);
        addr_case(8'h05, 8'h13, 32'h81223344, 4, 32'h01223344);
        addr_case(8'h85, 8'h13, 32'h00000001, 4, 32'h00000001);
    endtask : t_addr

    task automatic t_soft_reset();
        tx[0] = abm_pkg::CMD_WREN;
        run_frame(1);
        bank_wr(8'h85);
        tx[0] = abm_pkg::CMD_SOFT_RST;
        run_frame(1);
        check(bank_sel, 32'h00, "bank after soft reset");
        check(addr_4byte, 32'h0, "mode after soft reset");
        tx[0] = abm_pkg::CMD_SR1_RD;
        run_frame(2);
        check(rx[1], 32'h00, "enable after soft reset");
    endtask : t_soft_reset

    task automatic t_hard_reset();
        bank_wr(8'hff);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(bank_sel, 32'h00, "bank after hw reset");
    endtask : t_hard_reset

    task automatic sr1_read(input logic [7:0] exp);
        tx[0] = abm_pkg::CMD_SR1_RD;
        run_frame(2);
        check(rx[1], exp, "status read");
    endtask : sr1_read

    task automatic t_status_wel();
        tx[0] = abm_pkg::CMD_SR1_WR;
        tx[1] = 8'hfc;
        run_frame(2);
        sr1_read(8'h00);
        tx[0] = abm_pkg::CMD_WREN;
        run_frame(1);
        sr1_read(8'h02);
        tx[0] = abm_pkg::CMD_SR1_WR;
        tx[1] = 8'hff;
        run_frame(2);
        sr1_read(8'hfc);
    endtask : t_status_wel

    task automatic t_sfdp();
        logic [63:0] exp;
        exp = 64'hf028faa8ff0000ff;
        for (int m = 0; m < 2; m++) begin
            // Four-byte mode must not stretch the discovery address
            bank_wr(m == 0 ? 8'h00 : 8'h80);
            tx[0] = abm_pkg::CMD_SFDP_RD;
            tx[1] = 8'h00;
            tx[2] = 8'h00;
            tx[3] = 8'h3c;
            tx[4] = 8'h55;
            for (int i = 5; i < 13; i++)
                tx[i] = 8'h00;
            run_frame(13);
            for (int i = 0; i < 8; i++)
                check(rx[5 + i], exp[63 - 8 * i -: 8],
                      "table byte");
        end
    endtask : t_sfdp

    // Watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        complete_run();
    end

    initial begin
        rst_b   = 1'b0;
        req_cnt = 0;
        fails   = 0;
        n_tests = 0;
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset_values();
        t_bank_rw();
        t_bank_refused();
        t_addr();
        t_soft_reset();
        t_hard_reset();
        t_status_wel();
        t_sfdp();
        complete_run();
    end
endmodule : abm_top_tb_top
